// file: design/ncp_core.sv
// Purpose: Channel A oscillator with two frequency/phase presets and byte registers
// Assumes: One sample clock; register writes arrive as byte strobes on it
// Notes: Presets 2/3, channel B and sync control live elsewhere
`timescale 1ns/1ps
module ncp_core
   import ncp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire ncp_wr_t wr,
   input wire logic [11:0] rd_addr,
   output logic [7:0] rd_data,
   // Oscillator control
   input wire logic preset_sel,
   input wire logic phase_init,
   input wire logic interleaved,
   input wire logic [15:0] reference_divisor,
   // Oscillator output
   output logic [31:0] osc_phase,
   output logic divisor_active
);
   // ==========================================================
   // Register state
   logic [31:0] freq_word_a_preset0_reg, freq_word_a_preset0_next; // Preset 0 word
   logic [31:0] freq_word_a_preset1_reg, freq_word_a_preset1_next; // Preset 1 word
   logic [15:0] phase_offset_a_preset0_reg, phase_offset_a_preset0_next; // Preset 0 phase
   logic [15:0] phase_offset_a_preset1_reg, phase_offset_a_preset1_next; // Preset 1 phase
   logic [7:0] rd_data_next; // Read byte
   // ==========================================================
   // Address decode
   // Each word register is seen as a run of byte lanes from its base.
   // A lane code with bit 2 set means the address misses that register.
   // The decode is kept in named variables instead of indexing a function
   // result, since a bit-select of a call is not legal in every front end.
   logic [2:0] wl_f0; // Write lane, preset 0 word
   logic [2:0] wl_f1; // Write lane, preset 1 word
   logic [2:0] wl_p0; // Write lane, preset 0 phase
   logic [2:0] wl_p1; // Write lane, preset 1 phase
   logic [2:0] rl_f0; // Read lane, preset 0 word
   logic [2:0] rl_f1; // Read lane, preset 1 word
   logic [2:0] rl_p0; // Read lane, preset 0 phase
   logic [2:0] rl_p1; // Read lane, preset 1 phase
   // Byte lane of a word register, or none
   function automatic logic [2:0] lane(input logic [11:0] a, input logic [11:0] base, input int n);
      lane = 3'h4;
      if (a >= base && a < base + 12'(n))
         lane = {1'b0, 2'(a - base)};
   endfunction
   // Register writes and read mux
   always_comb begin
      // Decode both ports first; every later branch reads these
      wl_f0 = lane(wr.addr, OFS_FREQ_A0, 4);
      wl_f1 = lane(wr.addr, OFS_FREQ_A1, 4);
      wl_p0 = lane(wr.addr, OFS_PHASE_A0, 2);
      wl_p1 = lane(wr.addr, OFS_PHASE_A1, 2);
      rl_f0 = lane(rd_addr, OFS_FREQ_A0, 4);
      rl_f1 = lane(rd_addr, OFS_FREQ_A1, 4);
      rl_p0 = lane(rd_addr, OFS_PHASE_A0, 2);
      rl_p1 = lane(rd_addr, OFS_PHASE_A1, 2);
      // Default: every preset register keeps its value; the read byte is zero
      freq_word_a_preset0_next = freq_word_a_preset0_reg;
      freq_word_a_preset1_next = freq_word_a_preset1_reg;
      phase_offset_a_preset0_next = phase_offset_a_preset0_reg;
      phase_offset_a_preset1_next = phase_offset_a_preset1_reg;
      rd_data_next = 8'h00;
      if (wr.we) begin
         // Each byte lands in its own lane; word applies on the next cycle
         // A half-written word is live in between, so software should
         // resync after the last byte if phase must be deterministic
         if (!wl_f0[2]) begin
            freq_word_a_preset0_next[wl_f0[1:0]*8 +: 8] = wr.data;
         end
         if (!wl_f1[2]) begin
            freq_word_a_preset1_next[wl_f1[1:0]*8 +: 8] = wr.data;
         end
         if (!wl_p0[2]) begin
            phase_offset_a_preset0_next[wl_p0[0]*8 +: 8] = wr.data;
         end
         if (!wl_p1[2]) begin
            phase_offset_a_preset1_next[wl_p1[0]*8 +: 8] = wr.data;
         end
      end
      // Readback; unmapped bytes read zero
      if (!rl_f0[2]) begin
         rd_data_next = freq_word_a_preset0_reg[rl_f0[1:0]*8 +: 8];
      end else if (!rl_f1[2]) begin
         rd_data_next = freq_word_a_preset1_reg[rl_f1[1:0]*8 +: 8];
      end else if (!rl_p0[2]) begin
         rd_data_next = phase_offset_a_preset0_reg[rl_p0[0]*8 +: 8];
      end else if (!rl_p1[2]) begin
         rd_data_next = phase_offset_a_preset1_reg[rl_p1[0]*8 +: 8];
      end
   end
   // Register storage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         freq_word_a_preset0_reg <= RST_FREQ;
         freq_word_a_preset1_reg <= RST_FREQ;
         phase_offset_a_preset0_reg <= RST_PHASE;
         phase_offset_a_preset1_reg <= RST_PHASE;
         rd_data <= 8'h00;
      end else begin
         freq_word_a_preset0_reg <= freq_word_a_preset0_next;
         freq_word_a_preset1_reg <= freq_word_a_preset1_next;
         phase_offset_a_preset0_reg <= phase_offset_a_preset0_next;
         phase_offset_a_preset1_reg <= phase_offset_a_preset1_next;
         rd_data <= rd_data_next;
      end
   end
   // ==========================================================
   // Oscillator
   logic [31:0] acc_reg, acc_next; // Phase accumulator
   logic [31:0] osc_phase_next; // Accumulator plus offset
   logic [31:0] step; // Selected word
   logic [31:0] offs; // Left-justified phase
   logic divisor_active_next; // Divisor in use
   // Only channel A words exist here, so interleaved mode needs no change
   // The interleaved input is kept on the port so the wider device can
   // steer channel B presets elsewhere; this block never reads it.
   // Offset is added after the accumulator, not into it, so a phase
   // rewrite moves the output at once without disturbing the frequency.
   // Trade-off: one extra adder in exchange for glitch-free phase steps.
   always_comb begin
      step = preset_sel ? freq_word_a_preset1_reg : freq_word_a_preset0_reg;
      offs = {preset_sel ? phase_offset_a_preset1_reg : phase_offset_a_preset0_reg, 16'h0000};
      // Modulo 2^32 sum: signed and unsigned words act alike
      acc_next = phase_init ? 32'h00000000 : acc_reg + step;
      osc_phase_next = acc_next + offs;
      // Zero divisor means plain accumulator; the fractional path is external
      divisor_active_next = (reference_divisor != 16'h0000);
   end
   // Oscillator state
   // Output is registered so downstream mixers see a clean word each cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc_reg <= 32'h00000000;
         osc_phase <= 32'h00000000;
         divisor_active <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         osc_phase <= osc_phase_next;
         divisor_active <= divisor_active_next;
      end
   end
   // ==========================================================
   // Checks
   // All checks are disabled while reset is high, apart from the ones
   // that look at the values reset leaves behind.
   // Accumulator and output are registered in the same cycle, so the output
   // check adds the previous cycle's offset to the current accumulator.
   a_acc_step: assert property (@(posedge clk_sys) disable iff (rst)
      !phase_init && !$past(rst) |=> acc_reg == $past(acc_reg) + $past(step))
      else $error("accumulator step wrong");
   a_phase_sum: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> osc_phase == acc_reg + $past(offs))
      else $error("phase offset sum wrong");
   a_reset_vals: assert property (@(posedge clk_sys)
      rst |=> freq_word_a_preset1_reg == RST_FREQ && phase_offset_a_preset1_reg == 16'h0000)
      else $error("preset 1 reset wrong");
   a_ph0_reset: assert property (@(posedge clk_sys) rst |=> phase_offset_a_preset0_reg == 16'h0000)
      else $error("preset 0 phase reset wrong");
   a_ph1_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !wr.we |=> $stable(phase_offset_a_preset1_reg))
      else $error("preset 1 phase changed");
   a_div_flag: assert property (@(posedge clk_sys) disable iff (rst)
      reference_divisor == 16'h0000 |=> !divisor_active)
      else $error("divisor flag wrong");
   a_preset0_step: assert property (@(posedge clk_sys) disable iff (rst)
      !preset_sel && !phase_init |=> acc_reg == $past(acc_reg) + $past(freq_word_a_preset0_reg))
      else $error("preset 0 step wrong");
   a_preset1_step: assert property (@(posedge clk_sys) disable iff (rst)
      preset_sel && !phase_init |=> acc_reg == $past(acc_reg) + $past(freq_word_a_preset1_reg))
      else $error("preset 1 step wrong");
   a_f1_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !wr.we |=> $stable(freq_word_a_preset1_reg))
      else $error("preset 1 word changed");
   a_ph0_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !wr.we |=> $stable(phase_offset_a_preset0_reg))
      else $error("preset 0 phase changed");
   a_div_on: assert property (@(posedge clk_sys) disable iff (rst)
      reference_divisor != 16'h0000 |=> divisor_active)
      else $error("divisor flag not set");
   a_init_zero: assert property (@(posedge clk_sys) disable iff (rst)
      phase_init |=> acc_reg == 32'h00000000)
      else $error("init not zero");
endmodule // ncp_core

// file: include/ncp_pkg.sv
// Purpose: Shared constants and types for the channel A oscillator presets
// Assumes: Byte-addressed register port, 8-bit data lanes as on the serial port
// Notes: Offsets are byte addresses of the least significant byte of each word
package ncp_pkg;
   // ==========================================================
   // Register map
   localparam logic [11:0] OFS_FREQ_A0 = 12'h220;    // Frequency word, preset 0
   localparam logic [11:0] OFS_PHASE_A0 = 12'h224;   // Phase value, preset 0
   localparam logic [11:0] OFS_FREQ_A1 = 12'h228;    // Frequency word, preset 1
   localparam logic [11:0] OFS_PHASE_A1 = 12'h22c;   // Phase value, preset 1
   // ==========================================================
   // Reset values
   localparam logic [31:0] RST_FREQ = 32'hc0000000;  // Both frequency presets
   localparam logic [15:0] RST_PHASE = 16'h0000;     // Both phase presets
   // ==========================================================
   // Widths
   localparam int ACC_W = 32;                        // Accumulator width
   localparam int PH_W = 16;                         // Phase value width
   // Register write strobe with its byte
   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [7:0] data;
   } ncp_wr_t;
endpackage

// file: sim/ncp_core_tb.sv
// Purpose: Self-checking bench for the channel A oscillator presets
// Assumes: Byte register port, registered read one cycle after address
// Notes: Oscillator rate checked by phase differences, so accumulator latency drops out; output after a clear checked absolute
`timescale 1ns/1ps
module ncp_core_tb
   import ncp_pkg::*;
;
   // ==========================================================
   // Stimulus and observed signals
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic preset_sel = 1'b0;
   logic phase_init = 1'b0;
   logic interleaved = 1'b0;
   logic [11:0] rd_addr = 12'h000;
   logic [15:0] reference_divisor = 16'h0000;
   ncp_wr_t wr = '0;
   logic [7:0] rd_data;
   logic [31:0] osc_phase;
   logic [31:0] p0; // Phase snapshot
   logic divisor_active;
   int err_total = 0;
   int num_checks = 0;
   // 250 MHz sample clock
   always #2 clk_sys = ~clk_sys;
   ncp_core dut (.clk_sys(clk_sys), .rst(rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
      .preset_sel(preset_sel), .phase_init(phase_init), .interleaved(interleaved),
      .reference_divisor(reference_divisor), .osc_phase(osc_phase), .divisor_active(divisor_active));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Little-endian byte writes, back to back
   task automatic wr_reg(input logic [11:0] a, input int n, input logic [31:0] d);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         wr <= '{1'b1, a + 12'(i), d[8*i+:8]};
      end
      @(posedge clk_sys);
      wr <= '0;
   endtask
   // Read n bytes and compare each
   task automatic chk_reg(input logic [11:0] a, input int n, input logic [31:0] e);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         rd_addr <= a + 12'(i);
         @(posedge clk_sys);
         #1 check({24'h0, rd_data}, {24'h0, e[8*i+:8]});
      end
   endtask
   // Phase advance over n cycles, after selects settle
   task automatic span(input int n, input logic [31:0] e);
      repeat (3) @(posedge clk_sys);
      #1 p0 = osc_phase;
      repeat (n) @(posedge clk_sys);
      #1 check(osc_phase - p0, e);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      chk_reg(OFS_FREQ_A0, 4, RST_FREQ);
      chk_reg(OFS_FREQ_A1, 4, RST_FREQ);
      chk_reg(OFS_PHASE_A0, 2, 32'(RST_PHASE));
      chk_reg(OFS_PHASE_A1, 2, 32'(RST_PHASE));
      // Unmapped place keeps nothing
      wr_reg(12'h230, 1, 32'h5a);
      chk_reg(12'h230, 1, 32'h0);
      wr_reg(OFS_FREQ_A0, 4, 32'h01234567);
      chk_reg(OFS_FREQ_A0, 4, 32'h01234567);
      wr_reg(OFS_FREQ_A1, 4, 32'hfedcba98);
      chk_reg(OFS_FREQ_A1, 4, 32'hfedcba98);
      wr_reg(OFS_PHASE_A1, 2, 32'h8001);
      chk_reg(OFS_PHASE_A1, 2, 32'h8001);
      span(10, 32'h01234567 * 10);
      @(posedge clk_sys);
      preset_sel <= 1'b1;
      interleaved <= 1'b1;
      span(7, 32'hfedcba98 * 7);
      // Offset change mid-run shows as a left-justified step
      #1 p0 = osc_phase;
      wr_reg(OFS_PHASE_A1, 2, 32'h4001);
      repeat (3) @(posedge clk_sys);
      #1 check(osc_phase - p0, 32'hfedcba98 * 6 + 32'hc0000000);
      // Zero word after a clear leaves only the offset
      wr_reg(OFS_FREQ_A1, 4, 32'h0);
      phase_init <= 1'b1;
      @(posedge clk_sys);
      phase_init <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 check(osc_phase, 32'h40010000);
      @(posedge clk_sys);
      reference_divisor <= 16'h0001;
      repeat (3) @(posedge clk_sys);
      #1 check({31'h0, divisor_active}, 32'h1);
      @(posedge clk_sys);
      reference_divisor <= 16'h0000;
      repeat (3) @(posedge clk_sys);
      #1 check({31'h0, divisor_active}, 32'h0);
      results();
   end
   // Hang guard
   initial begin
      #20000;
      err_total++;
      results();
   end
endmodule // ncp_core_tb
